// ===== core/rccr_top.sv
// Channel-2 control and channel-0 alternate voltage registers with their decodes
`timescale 1ns/1ps
`include "rccr_map.svh"
module rccr_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire rccr_pkg::rccr_req_t req_i,
  input wire logic [7:0] otp_ch2_ctrl_i,
  input wire logic [3:0] seq_slot_on_i,
  output logic [7:0] rdata_o,
  output rccr_pkg::rccr_topo_t topology_o,
  output logic [9:0] peak_limit_ma_o,
  output logic ch2_on_o,
  output logic ch2_discharge_on_o,
  output logic [12:0] ch0_alt_mv_o
);
  import rccr_pkg::*;

  rccr_ch2_cfg_t ch2_ff;
  rccr_ch2_cfg_t nxt_ch2;
  logic [7:0] alt_ff;
  logic [7:0] nxt_alt;
  logic otp_done_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  rccr_topo_t topo_ff;
  logic [9:0] ipk_ff;
  logic [9:0] nxt_ipk;
  logic on_ff;
  logic nxt_on;
  logic dis_ff;
  logic nxt_dis;
  logic [12:0] mv_ff;
  logic [12:0] nxt_mv;

  wire hit_ch2 = (req_i.addr == `RCCR_OFS_CH2_CTRL);
  wire hit_alt = (req_i.addr == `RCCR_OFS_CH0_ALT);
  wire wr_ch2 = req_i.wr_en & hit_ch2;
  wire wr_alt = req_i.wr_en & hit_alt;

  // Factory values arrive on a port, so they are caught on the first edge after release, not in reset
  assign nxt_ch2 = !otp_done_ff ? rccr_ch2_cfg_t'(otp_ch2_ctrl_i) :
                   wr_ch2 ? rccr_ch2_cfg_t'(req_i.wdata) : ch2_ff;
  assign nxt_alt = wr_alt ? req_i.wdata : alt_ff;

  // Unmapped offsets read as zero
  assign nxt_rdata = !req_i.rd_en ? rdata_ff :
                     hit_ch2 ? 8'(ch2_ff) :
                     hit_alt ? alt_ff : 8'h00;

  wire [2:0] en_code = ch2_ff.ch2_enable_slot;
  wire slot_on = seq_slot_on_i[en_code[1:0]];

  always_comb begin
    nxt_on = 1'b0;
    case (en_code)
      3'h0, 3'h1, 3'h2, 3'h3: nxt_on = slot_on;
      3'h4, 3'h5: nxt_on = 1'b0;
      3'h6, 3'h7: nxt_on = 1'b1;
      default: nxt_on = 1'b0;
    endcase
  end

  // Pull-down only while the channel is off and active discharge is armed
  assign nxt_dis = ch2_ff.ch2_discharge_enable & ~nxt_on;

  always_comb begin
    nxt_ipk = `RCCR_IPK0_MA;
    case (ch2_ff.ch2_peak_current_code)
      2'h0: nxt_ipk = `RCCR_IPK0_MA;
      2'h1: nxt_ipk = `RCCR_IPK1_MA;
      2'h2: nxt_ipk = `RCCR_IPK2_MA;
      2'h3: nxt_ipk = `RCCR_IPK3_MA;
      default: nxt_ipk = `RCCR_IPK0_MA;
    endcase
  end

  // Product of an 8-bit code and 25 fits 13 bits; the clamp keeps the top of range at 5.5V
  wire [12:0] lin_mv = `RCCR_VMIN_MV + 13'(alt_ff * `RCCR_VSTEP_MV);
  assign nxt_mv = (alt_ff >= `RCCR_VCLAMP_CODE) ? `RCCR_VMAX_MV : lin_mv;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ch2_ff <= rccr_ch2_cfg_t'(`RCCR_RST_CH2_CTRL);
      alt_ff <= `RCCR_RST_CH0_ALT;
      otp_done_ff <= 1'b0;
    end else begin
      ch2_ff <= nxt_ch2;
      alt_ff <= nxt_alt;
      otp_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_ff <= 8'h00;
      topo_ff <= RCCR_TOPO_AUTO;
      ipk_ff <= `RCCR_IPK0_MA;
      on_ff <= 1'b0;
      dis_ff <= 1'b0;
      // Decoded target matches the reset code so the pin agrees with the register out of reset; after a write it follows one edge later
      mv_ff <= `RCCR_RST_CH0_MV;
    end else begin
      rdata_ff <= nxt_rdata;
      topo_ff <= ch2_ff.converter_topology_select;
      ipk_ff <= nxt_ipk;
      on_ff <= nxt_on;
      dis_ff <= nxt_dis;
      mv_ff <= nxt_mv;
    end
  end

  assign rdata_o = rdata_ff;
  assign topology_o = topo_ff;
  assign peak_limit_ma_o = ipk_ff;
  assign ch2_on_o = on_ff;
  assign ch2_discharge_on_o = dis_ff;
  assign ch0_alt_mv_o = mv_ff;

  // Bias low-power sequencing is left to host software; nothing here blocks an enable write

  sequence s_wr_ch2;
    otp_done_ff && req_i.wr_en && req_i.addr == `RCCR_OFS_CH2_CTRL;
  endsequence

  sequence s_rd_ch2;
    req_i.rd_en && req_i.addr == `RCCR_OFS_CH2_CTRL && !req_i.wr_en;
  endsequence

  sequence s_wr_alt;
    req_i.wr_en && req_i.addr == `RCCR_OFS_CH0_ALT;
  endsequence

  sequence s_rd_alt;
    req_i.rd_en && req_i.addr == `RCCR_OFS_CH0_ALT && !req_i.wr_en;
  endsequence

  sequence s_rd_other;
    req_i.rd_en && req_i.addr != `RCCR_OFS_CH2_CTRL && req_i.addr != `RCCR_OFS_CH0_ALT;
  endsequence

  AST_MODE_FOLLOWS: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_wr_ch2 |-> ##2 topology_o == rccr_topo_t'($past(req_i.wdata[7:6], 2)))
    else $error("topology output does not follow written mode");

  AST_PEAK_LIMIT: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_wr_ch2 ##1 1'b1 |=> peak_limit_ma_o ==
      ($past(req_i.wdata[5:4], 2) == 2'h0 ? `RCCR_IPK0_MA :
       $past(req_i.wdata[5:4], 2) == 2'h1 ? `RCCR_IPK1_MA :
       $past(req_i.wdata[5:4], 2) == 2'h2 ? `RCCR_IPK2_MA : `RCCR_IPK3_MA))
    else $error("peak limit decode wrong");

  AST_NO_PULLDOWN: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(!ch2_ff.ch2_discharge_enable) && otp_done_ff |-> !ch2_discharge_on_o)
    else $error("pull-down active with discharge disabled");

  AST_PULLDOWN_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_wr_ch2 and (req_i.wdata[3] && req_i.wdata[2:1] == 2'b10) |-> ##2 ch2_discharge_on_o && !ch2_on_o)
    else $error("discharge resistor not on when channel held off");

  AST_SLOT_FOLLOW: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !ch2_ff.ch2_enable_slot[2] |=> ch2_on_o == $past(seq_slot_on_i[ch2_ff.ch2_enable_slot[1:0]]))
    else $error("channel does not follow its sequencer slot");

  AST_FORCED_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ch2_ff.ch2_enable_slot[2:1] == 2'b10) [*2] |-> !ch2_on_o)
    else $error("channel on while held off");

  AST_FORCED_ON: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ch2_ff.ch2_enable_slot[2:1] == 2'b11) [*2] |-> ch2_on_o && !ch2_discharge_on_o)
    else $error("channel off while forced on");

  AST_ALT_LINEAR: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(alt_ff) < `RCCR_VCLAMP_CODE |-> ch0_alt_mv_o == `RCCR_VMIN_MV + 13'($past(alt_ff)) * `RCCR_VSTEP_MV)
    else $error("alternate voltage not linear");

  AST_ALT_CLAMP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(alt_ff) >= `RCCR_VCLAMP_CODE |-> ch0_alt_mv_o == `RCCR_VMAX_MV)
    else $error("alternate voltage not clamped");

  AST_READBACK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_wr_ch2 ##1 s_rd_ch2 |=> rdata_o == $past(req_i.wdata, 2))
    else $error("read does not return last write");

  // Storage checks: registers move only on a write, and the factory load lands on the first edge
  AST_READBACK_ALT: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_wr_alt ##1 s_rd_alt |=> rdata_o == $past(req_i.wdata, 2))
    else $error("alternate voltage read does not return last write");

  AST_UNMAPPED_READ: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_rd_other |=> rdata_o == 8'h00)
    else $error("unmapped read returned nonzero data");

  AST_RDATA_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !req_i.rd_en |=> $stable(rdata_o))
    else $error("read data changed without a read");

  AST_OTP_CAPTURE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !otp_done_ff |=> 8'(ch2_ff) == $past(otp_ch2_ctrl_i))
    else $error("factory value not loaded after reset");

  AST_CH2_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    otp_done_ff && !wr_ch2 |=> $stable(ch2_ff))
    else $error("channel-2 control changed without a write");

  AST_ALT_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !wr_alt |=> $stable(alt_ff))
    else $error("alternate voltage changed without a write");

  AST_DISCHARGE_EXCL: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ch2_discharge_on_o |-> !ch2_on_o)
    else $error("discharge resistor on while channel on");

  AST_PULLDOWN_ARMED: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(ch2_ff.ch2_discharge_enable) && !ch2_on_o |-> ch2_discharge_on_o)
    else $error("discharge resistor off while armed and channel off");

  AST_PEAK_LEGAL: assert property (@(posedge clk_i) disable iff (!nrst_i)
    peak_limit_ma_o inside {`RCCR_IPK0_MA, `RCCR_IPK1_MA, `RCCR_IPK2_MA, `RCCR_IPK3_MA})
    else $error("peak limit outside the four legal values");

  AST_ALT_RANGE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ch0_alt_mv_o >= `RCCR_VMIN_MV && ch0_alt_mv_o <= `RCCR_VMAX_MV)
    else $error("alternate voltage outside the output range");

endmodule : rccr_top

// ===== pkg/rccr_map.svh
// Register offsets, field positions, reset values and decode constants for the channel config bank
`ifndef RCCR_MAP_SVH
`define RCCR_MAP_SVH
`define RCCR_OFS_CH2_CTRL 8'h2e
`define RCCR_OFS_CH0_ALT 8'h2f
`define RCCR_RST_CH2_CTRL 8'h04
`define RCCR_RST_CH0_ALT 8'h14
`define RCCR_RST_CH0_MV 13'd1000
`define RCCR_BIT_MODE_HI 7
`define RCCR_BIT_MODE_LO 6
`define RCCR_BIT_IPK_HI 5
`define RCCR_BIT_IPK_LO 4
`define RCCR_BIT_ADE 3
`define RCCR_BIT_EN_HI 2
`define RCCR_BIT_EN_LO 0
`define RCCR_IPK0_MA 10'd1000
`define RCCR_IPK1_MA 10'd750
`define RCCR_IPK2_MA 10'd500
`define RCCR_IPK3_MA 10'd333
`define RCCR_VMIN_MV 13'd500
`define RCCR_VSTEP_MV 13'd25
`define RCCR_VMAX_MV 13'd5500
`define RCCR_VCLAMP_CODE 8'hc8
`endif

// ===== pkg/rccr_pkg.sv
// Types shared by the channel config bank
package rccr_pkg;
  typedef enum logic [1:0] {
    RCCR_TOPO_AUTO,
    RCCR_TOPO_BUCK,
    RCCR_TOPO_BOOST,
    RCCR_TOPO_BUCK_BOOST
  } rccr_topo_t;
  typedef struct packed {
    rccr_topo_t converter_topology_select;
    logic [1:0] ch2_peak_current_code;
    logic ch2_discharge_enable;
    logic [2:0] ch2_enable_slot;
  } rccr_ch2_cfg_t;
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rccr_req_t;
endpackage : rccr_pkg

// ===== sim/rccr_top_tb.sv
// Self-checking bench for the channel config register bank
`timescale 1ns/1ps
module rccr_top_tb;
  import rccr_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  rccr_req_t req_i = '0;
  logic [7:0] otp_ch2_ctrl_i = 8'hb9;
  logic [3:0] seq_slot_on_i = 4'h0;
  logic [7:0] rdata_o;
  rccr_topo_t topology_o;
  logic [9:0] peak_limit_ma_o;
  logic ch2_on_o;
  logic ch2_discharge_on_o;
  logic [12:0] ch0_alt_mv_o;
  int err_count = 0;
  int n_tests = 0;
  int m_ctrl;
  int m_alt;
  int peak_q[$] = '{1000, 750, 500, 333};
  logic [7:0] addr_q[$] = '{8'h2e, 8'h2f, 8'h30, 8'h2d};
  logic [7:0] alt_q[$] = '{8'h00, 8'hc7, 8'hc8, 8'hff};
  logic [31:0] seed = 32'h82dc15ee;

  rccr_top dut_u (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .req_i(req_i),
    .otp_ch2_ctrl_i(otp_ch2_ctrl_i),
    .seq_slot_on_i(seq_slot_on_i),
    .rdata_o(rdata_o),
    .topology_o(topology_o),
    .peak_limit_ma_o(peak_limit_ma_o),
    .ch2_on_o(ch2_on_o),
    .ch2_discharge_on_o(ch2_discharge_on_o),
    .ch0_alt_mv_o(ch0_alt_mv_o)
  );

  always #2.5 clk_i = ~clk_i;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Entered one step after a rising edge; the request stays up until the caller replaces or drops it
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    req_i = '{wr, !wr, addr, data};
    @(posedge clk_i);
    #1;
  endtask : access

  // Extra idle edge so decodes and the sequencer input have settled
  task automatic rd_chk(input logic [7:0] addr);
    int on;
    access(1'b0, addr, 8'h00);
    req_i = '0;
    @(posedge clk_i);
    #1 on = m_ctrl[2] ? m_ctrl[1] : seq_slot_on_i[m_ctrl[1:0]];
    chk(rdata_o, addr == 8'h2e ? m_ctrl : (addr == 8'h2f ? m_alt : 0));
    chk(topology_o, m_ctrl >> 6);
    chk(peak_limit_ma_o, peak_q[(m_ctrl >> 4) & 3]);
    chk(ch2_on_o, on);
    chk(ch2_discharge_on_o, m_ctrl[3] & !on);
    chk(ch0_alt_mv_o, m_alt >= 200 ? 5500 : 500 + 25 * m_alt);
  endtask : rd_chk

  task automatic step(input logic [7:0] addr, input logic [7:0] data);
    seed = lfsr_next(seed);
    seq_slot_on_i = seed[3:0];
    access(1'b1, addr, data);
    if (addr == 8'h2e) m_ctrl = data;
    else if (addr == 8'h2f) m_alt = data;
    rd_chk(addr);
  endtask : step

  task automatic final_report();
    $display("Checks: %0d, errors: %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (12) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    m_ctrl = 8'hb9;
    m_alt = 8'h14;
    @(posedge clk_i);
    #1 rd_chk(8'h2e);
    rd_chk(8'h2f);
    foreach (alt_q[i]) step(8'h2f, alt_q[i]);
    // Bias setting lives outside this bank; the host is taken to hold it at normal power here
    for (int i = 0; i < 16; i++) begin
      seed = lfsr_next(seed);
      step(8'h2e, {seed[11:8], i[3:0]});
    end
    for (int i = 0; i < 60; i++) begin
      seed = lfsr_next(seed);
      step(addr_q[seed[5:4]], seed[15:8]);
    end
    // Second reset mid-run with a fresh factory value
    seed = lfsr_next(seed);
    otp_ch2_ctrl_i = seed[23:16];
    nrst_i = 1'b0;
    #1 chk(ch0_alt_mv_o, 1000);
    chk(rdata_o, 0);
    repeat (3) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    m_ctrl = otp_ch2_ctrl_i;
    m_alt = 8'h14;
    @(posedge clk_i);
    #1 rd_chk(8'h2e);
    rd_chk(8'h2f);
    final_report();
  end
endmodule : rccr_top_tb
